/* src/card_port.sv */
// serial control port, command decode and card-side signal control
`timescale 1ns/10ps
`default_nettype none

module card_port (
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	input  wire logic serial_clk_in,
	input  wire logic serial_data_in,
	input  wire logic load_strobe_n_in,
	output logic      serial_data_out,
	input  wire logic card_presence_in,
	input  wire logic supply_ok_in,
	input  wire logic atr_fault_in,
	input  wire logic elec_fault_in,
	output logic      [1:0] card_supply_out,
	output logic      card_supply_en_out,
	input  wire logic reset_req_in,
	output logic      card_reset_out,
	input  wire logic sync_clk_in,
	output logic      sync_clk_out,
	output logic      sync_clk_oe_n_out,
	input  wire logic host_free_clock_in,
	input  wire logic card_clk_in,
	output logic      card_clk_out,
	output logic      card_clk_oe_n_out,
	input  wire logic host_data_in,
	output logic      host_data_out,
	output logic      host_data_oe_n_out,
	input  wire logic card_io_in,
	output logic      card_io_out,
	output logic      card_io_oe_n_out,
	output logic      aux_contact_a_out,
	output logic      aux_contact_b_out,
	output logic      fault_out,
	output logic      fault_oe_n_out
);
	import card_port_pkg::*;

	// next owner of a wired-low link; settle waits for both sides high
	// so our own released drive is not mistaken for the far side pulling
	function automatic owner_t owner_next(input owner_t cur, input logic a_low,
			input logic b_low, input logic enable);
		owner_t nxt;
		nxt = cur;
		if (!enable) begin
			nxt = OWN_IDLE;
		end else begin
			case (cur)
				OWN_IDLE: begin
					if (a_low) begin
						nxt = OWN_HOST;
					end else if (b_low) begin
						nxt = OWN_CARD;
					end
				end
				OWN_HOST: begin
					if (!a_low) begin
						nxt = OWN_SETTLE;
					end
				end
				OWN_CARD: begin
					if (!b_low) begin
						nxt = OWN_SETTLE;
					end
				end
				OWN_SETTLE: begin
					if (!a_low && !b_low) begin
						nxt = OWN_IDLE;
					end
				end
				default: nxt = OWN_IDLE;
			endcase
		end
		return nxt;
	endfunction

	pins_t         pins_raw;
	pins_t         sync1_ff;
	pins_t         sync2_ff;
	pins_t         sync3_ff;
	logic          sclk_rise;
	logic          ld_fall;
	logic          ld_rise;
	logic          free_rise;
	logic [7:0]    shift_ff;
	command_word_t cmd_ff;
	status_word_t  status;
	logic          elec_fault_ff;
	logic          atr_fault_ff;
	logic          deact;
	logic          live;
	logic          selected;
	owner_t        data_own_ff;
	owner_t        clk_own_ff;
	logic [2:0]    div_cnt_ff;
	logic          card_clk_ff;
	logic          nxt_card_clk;
	logic          div_src;
	logic          card_reset_ff;
	logic          aux_a_ff;
	logic          aux_b_ff;
	logic          supply_en_ff;
	logic [1:0]    supply_ff;
	logic          fault_oe_n_ff;

	assign pins_raw = '{sclk: serial_clk_in, din: serial_data_in,
		ld_n: load_strobe_n_in, present: card_presence_in, supply_ok: supply_ok_in,
		atr_fault: atr_fault_in, elec_fault: elec_fault_in, rst_req: reset_req_in,
		sync_clk: sync_clk_in, free_clk: host_free_clock_in, card_clk: card_clk_in,
		host_data: host_data_in, card_io: card_io_in};

	// two-stage synchroniser; third stage only for edge detection on stage two
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_ff <= PINS_IDLE;
			sync2_ff <= PINS_IDLE;
			sync3_ff <= PINS_IDLE;
		end else begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// edges; shift clock ignored while strobe low, it should not move then
	assign sclk_rise = sync2_ff.sclk && !sync3_ff.sclk && sync2_ff.ld_n;
	assign ld_fall   = !sync2_ff.ld_n && sync3_ff.ld_n;
	assign ld_rise   = sync2_ff.ld_n && !sync3_ff.ld_n;
	assign free_rise = sync2_ff.free_clk && !sync3_ff.free_clk;

	// status word as presented to the shift register
	assign status = '{present: sync2_ff.present, ready: live,
		atr_fault: atr_fault_ff, elec_fault: elec_fault_ff, zero: STATUS_ZERO}; // RULE8

	// shift register: status capture on strobe rise, shift on clock rise
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			shift_ff <= 8'h00;
		end else if (ld_rise) begin
			shift_ff <= status; // RULE4
		end else if (sclk_rise) begin
			shift_ff <= {shift_ff[6:0], sync2_ff.din}; // RULE1
		end
	end

	// msb drives the output, so a chained neighbour receives our old bits
	assign serial_data_out = shift_ff[7]; // RULE2 RULE6

	// command latch, takes effect on the strobe fall
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_ff <= CMD_RESET; // RULE23
		end else if (ld_fall) begin
			cmd_ff <= shift_ff; // RULE3
		end
	end

	// sticky faults cleared by loading shutdown; a new fault wins the clear
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			elec_fault_ff <= 1'b0;
			atr_fault_ff  <= 1'b0;
		end else begin
			if (sync2_ff.elec_fault) begin
				elec_fault_ff <= 1'b1; // RULE14
			end else if (ld_fall && shift_ff[1:0] == SUPPLY_OFF) begin
				elec_fault_ff <= 1'b0;
			end
			if (sync2_ff.atr_fault) begin
				atr_fault_ff <= 1'b1; // RULE14
			end else if (ld_fall && shift_ff[1:0] == SUPPLY_OFF) begin
				atr_fault_ff <= 1'b0;
			end
		end
	end

	// deactivation on shutdown code or electrical fault; card gated until ready
	assign deact    = (cmd_ff.supply == SUPPLY_OFF) || elec_fault_ff; // RULE10 RULE14
	assign live     = !deact && sync2_ff.supply_ok; // RULE13
	assign selected = live && cmd_ff.select; // RULE11

	// supply level and fault pin
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			supply_ff     <= SUPPLY_OFF;
			supply_en_ff  <= 1'b0;
			fault_oe_n_ff <= 1'b1;
		end else begin
			supply_ff     <= deact ? SUPPLY_OFF : cmd_ff.supply; // RULE9
			supply_en_ff  <= !deact; // RULE10
			fault_oe_n_ff <= !(elec_fault_ff || sync2_ff.elec_fault); // RULE20
		end
	end

	assign card_supply_out    = supply_ff;
	assign card_supply_en_out = supply_en_ff;
	assign fault_out          = 1'b0;
	assign fault_oe_n_out     = fault_oe_n_ff;

	// card reset follows host while selected, holds when deselected
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			card_reset_ff <= 1'b0;
		end else if (!live) begin
			card_reset_ff <= 1'b0; // RULE13
		end else if (selected) begin
			card_reset_ff <= sync2_ff.rst_req; // RULE11
		end
	end

	assign card_reset_out = card_reset_ff;

	// io link ownership; only active on the io route of a selected socket
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			data_own_ff <= OWN_IDLE;
		end else begin
			data_own_ff <= owner_next(data_own_ff, !sync2_ff.host_data, !sync2_ff.card_io,
				selected && cmd_ff.route == ROUTE_IO); // RULE17 RULE18
		end
	end

	// open-drain drives; unpowered card io is held low, deselected released
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			host_data_oe_n_out <= 1'b1;
			card_io_oe_n_out   <= 1'b0;
		end else begin
			host_data_oe_n_out <= !(data_own_ff == OWN_CARD); // RULE16 RULE18
			card_io_oe_n_out   <= !(!live || data_own_ff == OWN_HOST); // RULE13 RULE18
		end
	end

	assign host_data_out = 1'b0;
	assign card_io_out   = 1'b0;

	// aux contacts copy host data when routed, latch otherwise
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			aux_a_ff <= 1'b0;
			aux_b_ff <= 1'b0;
		end else if (!live) begin
			aux_a_ff <= 1'b0; // RULE13
			aux_b_ff <= 1'b0;
		end else if (selected) begin
			if (cmd_ff.route == ROUTE_AUX_A) begin
				aux_a_ff <= sync2_ff.host_data; // RULE17
			end
			if (cmd_ff.route == ROUTE_AUX_B) begin
				aux_b_ff <= sync2_ff.host_data; // RULE17
			end
		end
	end

	assign aux_contact_a_out = aux_a_ff;
	assign aux_contact_b_out = aux_b_ff;

	// free-running divider; counter bits give divide by 2, 4 and 8
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt_ff <= 3'h0;
		end else if (free_rise) begin
			div_cnt_ff <= div_cnt_ff + 3'h1;
		end
	end

	// divided source; mode switch is not glitch-filtered beyond the counter
	always_comb begin
		case (cmd_ff.clk_mode)
			CLK_DIV2: div_src = div_cnt_ff[0];
			CLK_DIV4: div_src = div_cnt_ff[1];
			CLK_DIV8: div_src = div_cnt_ff[2];
			default:  div_src = sync2_ff.free_clk;
		endcase
	end

	// card clock mode decode
	always_comb begin
		nxt_card_clk = card_clk_ff;
		if (!live) begin
			nxt_card_clk = 1'b0; // RULE13
		end else begin
			case (cmd_ff.clk_mode)
				CLK_SYNC: begin
					if (cmd_ff.select) begin
						nxt_card_clk = sync2_ff.sync_clk; // RULE19
					end
				end
				CLK_BIDIR: nxt_card_clk = 1'b0; // RULE19
				CLK_STOP_LO: begin
					nxt_card_clk = card_clk_ff && sync2_ff.free_clk; // RULE22
				end
				CLK_STOP_HI: begin
					nxt_card_clk = card_clk_ff || sync2_ff.free_clk; // RULE22
				end
				default: nxt_card_clk = div_src; // RULE12 RULE22
			endcase
		end
	end

	// bidirectional clock ownership, same wired-low scheme as the io link
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			clk_own_ff <= OWN_IDLE;
		end else begin
			clk_own_ff <= owner_next(clk_own_ff, !sync2_ff.sync_clk, !sync2_ff.card_clk,
				selected && cmd_ff.clk_mode == CLK_BIDIR); // RULE19
		end
	end

	// card clock register and pin enables
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			card_clk_ff       <= 1'b0;
			card_clk_oe_n_out <= 1'b0;
			sync_clk_oe_n_out <= 1'b1;
		end else begin
			card_clk_ff       <= nxt_card_clk; // RULE12
			card_clk_oe_n_out <= live && cmd_ff.clk_mode == CLK_BIDIR &&
				clk_own_ff != OWN_HOST;
			sync_clk_oe_n_out <= !(clk_own_ff == OWN_CARD);
		end
	end

	assign card_clk_out = card_clk_ff;
	assign sync_clk_out = 1'b0;

	// assertions
	sequence strobe_fall_s;
		ld_fall;
	endsequence
	sequence strobe_rise_s;
		ld_rise;
	endsequence
	a_load_latch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		strobe_fall_s |=> cmd_ff == $past(shift_ff)) // RULE3
		else $error("command latch did not take shift register");
	a_status_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		strobe_rise_s |=> shift_ff == $past(status) && shift_ff[3:0] == 4'h0) // RULE4
		else $error("status not captured on strobe rise");
	a_shift_in_msb: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		sclk_rise && !ld_rise |=> shift_ff == {$past(shift_ff[6:0]), $past(sync2_ff.din)}) // RULE1
		else $error("serial input not shifted in msb first");
	a_shift_out_bit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		sclk_rise && !ld_rise |=> serial_data_out == $past(shift_ff[6])) // RULE2
		else $error("next status bit missing on serial output");
	a_shutdown_supply: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cmd_ff.supply == SUPPLY_OFF [*2] |-> !card_supply_en_out && card_supply_out == 2'h0) // RULE10
		else $error("supply on during shutdown");
	a_fault_deact: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		elec_fault_ff |=> !card_supply_en_out ##1 !card_clk_out) // RULE14
		else $error("electrical fault did not deactivate card");
	a_fault_pin: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$rose(elec_fault_ff) |-> !fault_oe_n_out) // RULE20
		else $error("fault pin not pulled low");
	a_ready_block: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!live |=> !card_io_oe_n_out && !card_reset_out && !aux_contact_a_out) // RULE13
		else $error("card signals not blocked before supply ready");
	a_deselect_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!selected [*3] |-> host_data_oe_n_out) // RULE16
		else $error("deselected socket drives host data");
	a_route_aux: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		selected && cmd_ff.route == ROUTE_AUX_A |=>
		aux_contact_a_out == $past(sync2_ff.host_data)) // RULE17
		else $error("contact a does not follow host data");
endmodule

`default_nettype wire

/* src/card_port_pkg.sv */
// constants, field layouts and types of the smart card serial control port
// What the document requires of this block and its host
// RULE1 - serial input sampled on shift-clock rise, most significant bit first
// RULE2 - status bits shift out on the serial output as command bits shift in
// RULE3 - load strobe fall copies shift register into command latch, acted on at once
// RULE4 - load strobe rise captures current status into the shift register
// RULE5 - host keeps shift clock low at strobe fall, high at strobe rise
// RULE6 - serial output carries shifted bits onward for daisy-chained devices
// RULE7 - host keeps the shift clock at or below the maximum port rate
// RULE8 - status: present bit 7, ready bit 6, answer fault 5, electrical fault 4
// RULE9 - command bits 1..0 pick supply: off, 1.8 V, 3 V or 5 V
// RULE10 - supply bits both zero deactivate the card and switch supply off
// RULE11 - command bit 2 selects socket; reset, clock, data follow host pins
// RULE12 - command bits 7..5 choose card clock mode among eight options
// RULE13 - card signals stay blocked until supply ready, which status reports
// RULE14 - faults set status bits; electrical fault also deactivates the card
// RULE15 - host reads status only by a full transaction, may shift all zeros
// RULE16 - selected socket joins host data pin; deselected releases both sides
// RULE17 - command bits 4..3 route host data: none, contact a, contact b, io
// RULE18 - data path acts as wired open-drain link between both sides
// RULE19 - clock pattern 000 gives synchronous, 001 gives bidirectional mode
// RULE20 - open-drain fault output pulled low while electrical fault bit set
// RULE21 - host keeps shift clock high when idle, still while strobe low; the host model raises it once while strobe low
// RULE22 - stop modes have bit 7 clear, bit 6 set; dividers have bit 7 set
// RULE23 - command latch resets to zero: supply off, deselected, nothing routed
package card_port_pkg;

	// command latch layout and its reset value
	typedef struct packed {
		logic [2:0] clk_mode;
		logic [1:0] route;
		logic       select;
		logic [1:0] supply;
	} command_word_t;

	localparam command_word_t CMD_RESET = 8'h00;

	// status word layout, low nibble always zero
	typedef struct packed {
		logic       present;
		logic       ready;
		logic       atr_fault;
		logic       elec_fault;
		logic [3:0] zero;
	} status_word_t;

	localparam logic [3:0] STATUS_ZERO = 4'h0;

	// supply level codes
	localparam logic [1:0] SUPPLY_OFF   = 2'h0;
	localparam logic [1:0] SUPPLY_1V8   = 2'h1;
	localparam logic [1:0] SUPPLY_3V    = 2'h2;
	localparam logic [1:0] SUPPLY_5V    = 2'h3;

	// host data routing codes
	localparam logic [1:0] ROUTE_NONE   = 2'h0;
	localparam logic [1:0] ROUTE_AUX_A  = 2'h1;
	localparam logic [1:0] ROUTE_AUX_B  = 2'h2;
	localparam logic [1:0] ROUTE_IO     = 2'h3;

	// card clock mode codes
	localparam logic [2:0] CLK_SYNC     = 3'h0;
	localparam logic [2:0] CLK_BIDIR    = 3'h1;
	localparam logic [2:0] CLK_STOP_LO  = 3'h2;
	localparam logic [2:0] CLK_STOP_HI  = 3'h3;
	localparam logic [2:0] CLK_DIV1     = 3'h4;
	localparam logic [2:0] CLK_DIV2     = 3'h5;
	localparam logic [2:0] CLK_DIV4     = 3'h6;
	localparam logic [2:0] CLK_DIV8     = 3'h7;

	// pin inputs that cross into the system clock
	typedef struct packed {
		logic sclk;
		logic din;
		logic ld_n;
		logic present;
		logic supply_ok;
		logic atr_fault;
		logic elec_fault;
		logic rst_req;
		logic sync_clk;
		logic free_clk;
		logic card_clk;
		logic host_data;
		logic card_io;
	} pins_t;

	// idle pin levels; fault events idle low so a reset raises no false sticky fault
	localparam pins_t PINS_IDLE = 13'h1_F3F;

	// who pulls a wired-low link, one-hot
	typedef enum logic [3:0] {
		OWN_IDLE   = 4'b0001,
		OWN_HOST   = 4'b0010,
		OWN_CARD   = 4'b0100,
		OWN_SETTLE = 4'b1000
	} owner_t;

endpackage

/* testbench/card_port_bench.sv */
// bench for the card serial port: host transfers, decode and pin checks
`timescale 1ns/10ps
`default_nettype none

module card_port_bench;
	import card_port_pkg::*;
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        card_presence_in, supply_ok_in, atr_fault_in, elec_fault_in;
	logic        reset_req_in, sync_drv, host_pull, card_pull, clk_pull;
	logic        host_free_clock_in = 1'b0;
	wire         serial_clk_in, serial_data_in, load_strobe_n_in, serial_data_out;
	wire  [1:0]  card_supply_out;
	wire         card_supply_en_out, card_reset_out, sync_clk_oe_n_out, card_clk_out;
	wire         card_clk_oe_n_out, host_data_oe_n_out, card_io_oe_n_out;
	wire         aux_contact_a_out, aux_contact_b_out, fault_oe_n_out;
	wire         sync_clk_in, card_clk_in, host_data_in, card_io_in;
	int          bad_count   = 0;
	int          comparisons = 0;
	logic [15:0] got;
	int          n;

	// shared pins have pull-ups; a low from any party wins
	assign host_data_in = ~host_pull & host_data_oe_n_out;
	assign card_io_in   = ~card_pull & card_io_oe_n_out;
	assign sync_clk_in  = sync_drv & sync_clk_oe_n_out;
	assign card_clk_in  = ~clk_pull & (card_clk_oe_n_out | card_clk_out);

	// system clock, and a free clock of ten system periods
	always #5 clk_sys_in = ~clk_sys_in;
	always #50 host_free_clock_in = ~host_free_clock_in;

	card_port uut (
		.clk_sys_in, .rst_in, .serial_clk_in, .serial_data_in, .load_strobe_n_in,
		.serial_data_out, .card_presence_in, .supply_ok_in, .atr_fault_in,
		.elec_fault_in, .card_supply_out, .card_supply_en_out, .reset_req_in,
		.card_reset_out, .sync_clk_in, .sync_clk_out(), .sync_clk_oe_n_out,
		.host_free_clock_in, .card_clk_in, .card_clk_out, .card_clk_oe_n_out,
		.host_data_in, .host_data_out(), .host_data_oe_n_out, .card_io_in,
		.card_io_out(), .card_io_oe_n_out, .aux_contact_a_out, .aux_contact_b_out,
		.fault_out(), .fault_oe_n_out
	);

	serial_host_model host (
		.sclk_out (serial_clk_in),
		.din_out  (serial_data_in),
		.ld_n_out (load_strobe_n_in),
		.dout_in  (serial_data_out)
	);

	task automatic tally_and_finish();
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// counts may slip by one edge at the window ends
	task automatic check_near(input int g, input int e);
		comparisons++;
		if (g < e - 1 || g > e + 1) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wait_cyc(input int c);
		repeat (c) @(negedge clk_sys_in);
	endtask

	function automatic command_word_t mk(logic [2:0] m, logic [1:0] r, logic s, logic [1:0] v);
		return command_word_t'({m, r, s, v});
	endfunction

	// chained transfer: the inverted command goes first and must pass through
	task automatic send(input logic [7:0] cmd, input logic [7:0] stat);
		logic [7:0] inv;
		inv = ~cmd;
		host.xfer({inv, cmd}, got);
		wait_cyc(6);
		check(got[15:8], stat);
		check(got[7:0], inv);
	endtask

	task automatic count_rises(input int cycles, output int cnt);
		logic prev;
		cnt  = 0;
		prev = card_clk_out;
		repeat (cycles) begin
			@(negedge clk_sys_in);
			if (card_clk_out && !prev) cnt++;
			prev = card_clk_out;
		end
	endtask

	// a hang counts as a mismatch
	initial begin
		#900_000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		card_presence_in   = 1'b1;
		supply_ok_in       = 1'b1;
		atr_fault_in       = 1'b0;
		elec_fault_in      = 1'b0;
		reset_req_in       = 1'b0;
		clk_pull           = 1'b0;
		sync_drv           = 1'b1;
		host_pull          = 1'b0;
		card_pull          = 1'b0;
		wait_cyc(20);
		rst_in = 1'b0;
		wait_cyc(4);
		check({card_supply_en_out, card_supply_out, aux_contact_a_out, aux_contact_b_out,
			host_data_oe_n_out, fault_oe_n_out, card_reset_out}, 16'h0006);
		send(8'h00, 8'h00);
		check(card_supply_en_out, 1'b0);
		// every supply level; first status still shows the shutdown state
		for (int s = 1; s < 4; s++) begin
			send(mk(CLK_SYNC, ROUTE_NONE, 1'b1, s[1:0]), (s == 1) ? 8'h80 : 8'hC0);
			check({card_supply_en_out, card_supply_out}, {1'b1, s[1:0]});
		end
		// aux contacts follow the host pin only while routed, else hold
		for (int r = 1; r < 3; r++) begin
			send(mk(CLK_SYNC, r[1:0], 1'b1, SUPPLY_3V), 8'hC0);
			host_pull = 1'b1;
			wait_cyc(8);
			check({aux_contact_b_out, aux_contact_a_out}, (r == 1) ? 2'b00 : 2'b01);
			host_pull = 1'b0;
			wait_cyc(8);
			check({aux_contact_b_out, aux_contact_a_out}, (r == 1) ? 2'b01 : 2'b11);
		end
		// io link: lows cross both ways, release floats high
		send(mk(CLK_SYNC, ROUTE_IO, 1'b1, SUPPLY_3V), 8'hC0);
		host_pull = 1'b1;
		wait_cyc(8);
		check(card_io_oe_n_out, 1'b0);
		host_pull = 1'b0;
		wait_cyc(8);
		check(card_io_oe_n_out, 1'b1);
		card_pull = 1'b1;
		wait_cyc(8);
		check(host_data_oe_n_out, 1'b0);
		card_pull    = 1'b0;
		reset_req_in = 1'b1;
		wait_cyc(8);
		check({host_data_oe_n_out, card_reset_out}, 2'b11);
		// deselected: reset held, both data sides released
		send(mk(CLK_SYNC, ROUTE_IO, 1'b0, SUPPLY_3V), 8'hC0);
		reset_req_in = 1'b0;
		card_pull    = 1'b1;
		wait_cyc(8);
		check({card_reset_out, host_data_oe_n_out, card_io_oe_n_out}, 3'b111);
		card_pull = 1'b0;
		send(mk(CLK_SYNC, ROUTE_NONE, 1'b1, SUPPLY_3V), 8'hC0);
		for (int v = 0; v < 2; v++) begin
			sync_drv = v[0];
			wait_cyc(8);
			check(card_clk_out, v[0]);
		end
		// supply not ready: io held low and card clock forced low
		supply_ok_in = 1'b0;
		wait_cyc(8);
		check({card_io_oe_n_out, card_clk_out}, 2'b00);
		supply_ok_in = 1'b1;
		wait_cyc(8);
		send(mk(CLK_BIDIR, ROUTE_NONE, 1'b1, SUPPLY_3V), 8'hC0);
		sync_drv = 1'b0;
		wait_cyc(8);
		check({card_clk_oe_n_out, card_clk_out}, 2'b00);
		sync_drv = 1'b1;
		wait_cyc(8);
		check(card_clk_oe_n_out, 1'b1);
		// card side stretches the clock: host sync pin must follow low
		clk_pull = 1'b1;
		wait_cyc(8);
		check({sync_clk_oe_n_out, card_clk_oe_n_out}, 2'b01);
		clk_pull = 1'b0;
		wait_cyc(8);
		check(sync_clk_oe_n_out, 1'b1);
		// stop levels and divider rates; 80 free clock rises per window
		for (int m = 2; m < 8; m++) begin
			send(mk(m[2:0], ROUTE_NONE, 1'b1, SUPPLY_3V), 8'hC0);
			wait_cyc(100);
			count_rises(800, n);
			if (m < 4) check({card_clk_out, 8'(n)}, {m[0], 8'h00});
			else check_near(n, 80 >> (m - 4));
		end
		// faults: sticky, deactivate, cleared by the shutdown command
		send(mk(CLK_SYNC, ROUTE_NONE, 1'b1, SUPPLY_5V), 8'hC0);
		elec_fault_in = 1'b1;
		atr_fault_in  = 1'b1;
		wait_cyc(4);
		elec_fault_in = 1'b0;
		atr_fault_in  = 1'b0;
		wait_cyc(8);
		check({fault_oe_n_out, card_supply_en_out}, 2'b00);
		send(mk(CLK_SYNC, ROUTE_NONE, 1'b1, SUPPLY_5V), 8'hC0);
		send(8'h00, 8'hB0);
		check(fault_oe_n_out, 1'b1);
		host.half_ns = 50;
		send(8'h00, 8'h80);
		tally_and_finish();
	end
endmodule

`default_nettype wire

/* testbench/serial_host_model.sv */
// host model that shifts commands into the card serial port and reads status
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
	output logic      sclk_out,
	output logic      din_out,
	output logic      ld_n_out,
	input  wire logic dout_in
);
	// half period of the shift clock; 50 ns is the fastest legal rate
	int half_ns = 150;

	// idle: shift clock parked high, strobe released
	initial begin
		sclk_out = 1'b1;
		din_out  = 1'b0;
		ld_n_out = 1'b1;
	end

	// shift a chained word msb first, collect the serial output, then load
	task automatic xfer(input logic [15:0] word, output logic [15:0] got);
		got = 16'h0000;
		for (int i = 15; i >= 0; i--) begin
			sclk_out = 1'b0;
			din_out  = word[i];
			got[i]   = dout_in;
			#(half_ns);
			sclk_out = 1'b1;
			#(half_ns);
		end
		// seventeenth clock: low at strobe fall, high before strobe rise
		sclk_out = 1'b0;
		din_out  = ~din_out; // line is meaningless outside the frame
		#(half_ns);
		ld_n_out = 1'b0;
		#(half_ns);
		sclk_out = 1'b1;
		#(half_ns);
		ld_n_out = 1'b1;
		#(half_ns);
	endtask
endmodule

`default_nettype wire
